// file: hdl/flash_wake_pkg.sv
package flash_wake_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLDOFF_MS = 10; // write hold-off, longest figure
  localparam int HOLDOFF_CYCLES_DEF = HOLDOFF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SELECT_US = 10; // supply valid to first select
  localparam logic [9:0] SELECT_CYCLES =
    10'((SELECT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int WAKE_SHORT_NS_DEF = 3000; // plain default
  localparam int WAKE_READ_NS_DEF = 1800; // plain default

  // ----------------------------------------------------------------
  // frame bit positions
  // ----------------------------------------------------------------
  localparam logic [5:0] BIT_OP = 6'h08; // instruction byte done
  localparam logic [5:0] BIT_SIG = 6'h20; // three dummy bytes done
  localparam logic [5:0] BIT_FULL = 6'h28; // first signature done

  // ----------------------------------------------------------------
  // status layout and reset values
  // ----------------------------------------------------------------
  localparam int BUSY_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] WAKE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // opcode defaults and signature (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_RELEASE_DEF = 8'hA1;
  localparam logic [7:0] OP_DEEP_DEF = 8'hA2;
  localparam logic [7:0] OP_LATCH_SET_DEF = 8'hA3;
  localparam logic [7:0] OP_PAGE_WR_DEF = 8'hA4;
  localparam logic [7:0] OP_BLOCK_WIPE_DEF = 8'hA5;
  localparam logic [7:0] OP_ALL_WIPE_DEF = 8'hA6;
  localparam logic [7:0] OP_STATUS_WR_DEF = 8'hA7;
  localparam logic [7:0] SIGNATURE_DEF = 8'h5A; // arbitrary value

  // power state
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_DEEP = 2'b01,
    ST_WAKING = 2'b10
  } pwr_state_t;

endpackage

// file: hdl/flash_wake_signature_powerup.sv
`timescale 1ns/100ps
module flash_wake_signature_powerup
  import flash_wake_pkg::*;
#(
  parameter logic [7:0] OP_RELEASE = OP_RELEASE_DEF,
  parameter logic [7:0] OP_DEEP = OP_DEEP_DEF,
  parameter logic [7:0] OP_LATCH_SET = OP_LATCH_SET_DEF,
  parameter logic [7:0] OP_PAGE_WR = OP_PAGE_WR_DEF,
  parameter logic [7:0] OP_BLOCK_WIPE = OP_BLOCK_WIPE_DEF,
  parameter logic [7:0] OP_ALL_WIPE = OP_ALL_WIPE_DEF,
  parameter logic [7:0] OP_STATUS_WR = OP_STATUS_WR_DEF,
  parameter logic [7:0] SIGNATURE = SIGNATURE_DEF, // arbitrary value
  parameter int WAKE_SHORT_NS = WAKE_SHORT_NS_DEF,
  parameter int WAKE_READ_NS = WAKE_READ_NS_DEF,
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYCLES_DEF
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // reset, high; synchronous here, asynchronous in sig_shifter
  input wire logic sclk_in, // serial clock from host
  input wire logic cs_n_in, // chip select, low selects
  input wire logic mosi_in, // serial data in
  output logic miso_out, // serial data out
  output logic miso_oe_n_out, // low while driving data out
  input wire logic supply_on_clear_in, // supply below inhibit
  input wire logic supply_valid_in, // supply at operating level
  input wire logic cycle_active_in, // write/erase cycle running
  input wire logic write_latch_clear_in, // engine clears latch
  output logic cmd_valid_out, // pulse: opcode passed on
  output logic [7:0] cmd_code_out, // opcode passed on
  output logic deep_pd_out, // in deep power-down
  output logic waking_out, // wake delay running
  output logic write_ready_out, // write hold-off elapsed
  output logic [7:0] status_out // status bits
);
  // ----------------------------------------------------------------
  // wake delays: longest figures, rounded down, never under one
  // ----------------------------------------------------------------
  localparam int SHORT_RAW = WAKE_SHORT_NS / CLK_PERIOD_NS;
  localparam int READ_RAW = WAKE_READ_NS / CLK_PERIOD_NS;
  localparam logic [15:0] WAKE_SHORT_CYC =
    16'((SHORT_RAW < 1) ? 1 : SHORT_RAW);
  localparam logic [15:0] WAKE_READ_CYC =
    16'((READ_RAW < 1) ? 1 : READ_RAW);

  wake_link_if lnk ();

  logic core_rst, select_ok, write_ok, hold_rst;

  // ----------------------------------------------------------------
  // supply gating and serial side
  // ----------------------------------------------------------------
  power_gate #(
    .HOLDOFF_CYCLES(HOLDOFF_CYCLES)
  ) u_power (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .supply_on_clear_in(supply_on_clear_in),
    .supply_valid_in(supply_valid_in),
    .core_rst_out(core_rst),
    .select_ok_out(select_ok),
    .write_ok_out(write_ok)
  );

  sig_shifter #(
    .SIGNATURE(SIGNATURE)
  ) u_shift (
    .sclk_in(sclk_in),
    .cs_n_in(cs_n_in),
    .mosi_in(mosi_in),
    .rst_in(rst_in),
    .miso_out(miso_out),
    .miso_oe_n_out(miso_oe_n_out),
    .lnk(lnk.link_side)
  );

  // decode and power-state registers are reset while the supply is below threshold
  assign hold_rst = rst_in || core_rst;

  // ----------------------------------------------------------------
  // crossing from the serial clock
  // ----------------------------------------------------------------
  logic cs_meta, cs_sync, cs_prev;
  logic tog_meta, tog_sync, tog_prev;
  logic only_meta, only_sync, full_meta, full_sync;

  // two flip-flops per level, a third for edges
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_prev <= 1'b0;
      only_meta <= 1'b0;
      only_sync <= 1'b0;
      full_meta <= 1'b0;
      full_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
      tog_meta <= lnk.op_toggle;
      tog_sync <= tog_meta;
      tog_prev <= tog_sync;
      only_meta <= lnk.op_only;
      only_sync <= only_meta;
      full_meta <= lnk.sig_full;
      full_sync <= full_meta;
    end
  end

  logic op_evt, cs_rise, busy;
  logic [7:0] op;
  assign op_evt = tog_sync ^ tog_prev;
  assign cs_rise = cs_sync && !cs_prev;
  assign busy = cycle_active_in;
  assign op = lnk.op_byte; // stable once its toggle has crossed

  // ----------------------------------------------------------------
  // instruction decode and power state
  // ----------------------------------------------------------------
  pwr_state_t state, next_state;
  logic [15:0] wake_cnt, next_wake_cnt;
  logic rel_pend, next_rel_pend, from_deep, next_from_deep;
  logic deep_pend, next_deep_pend, lset_pend, next_lset_pend;
  logic write_latch_flag, next_wel;
  logic next_cmd_valid;
  logic [7:0] next_cmd_code, next_status;
  logic is_write;
  logic rel_hit, deep_hit, lset_hit, rel_any, deep_any, lset_any;

  always_comb begin
    is_write = (op == OP_PAGE_WR) || (op == OP_BLOCK_WIPE) ||
      (op == OP_ALL_WIPE) || (op == OP_STATUS_WR);
    rel_hit = 1'b0;
    deep_hit = 1'b0;
    lset_hit = 1'b0;
    next_state = state;
    next_wake_cnt = wake_cnt;
    next_rel_pend = rel_pend;
    next_from_deep = from_deep;
    next_deep_pend = deep_pend;
    next_lset_pend = lset_pend;
    next_wel = write_latch_flag;
    next_cmd_valid = 1'b0;
    next_cmd_code = cmd_code_out;
    // opcode arrival: nothing is served before the select delay
    if (op_evt && select_ok) begin
      unique case (state)
        ST_DEEP: begin
          rel_hit = (op == OP_RELEASE) && !busy;
        end
        ST_STANDBY: begin
          if (op == OP_RELEASE) begin
            rel_hit = !busy;
          end else if (op == OP_DEEP) begin
            deep_hit = 1'b1;
          end else if (op == OP_LATCH_SET) begin
            lset_hit = write_ok;
          end else if (!is_write || write_ok) begin
            next_cmd_valid = 1'b1;
            next_cmd_code = op;
          end
        end
        ST_WAKING: begin
          rel_hit = 1'b0; // host keeps deselected meanwhile
        end
      endcase
    end
    if (rel_hit) begin
      next_rel_pend = 1'b1;
      next_from_deep = (state == ST_DEEP);
    end
    next_deep_pend = next_deep_pend || deep_hit;
    next_lset_pend = next_lset_pend || lset_hit;
    rel_any = rel_pend || rel_hit;
    deep_any = deep_pend || deep_hit;
    lset_any = lset_pend || lset_hit;
    // wake countdown back to standby
    if (state == ST_WAKING) begin
      if (wake_cnt <= 16'h0001) begin
        next_state = ST_STANDBY;
        next_wake_cnt = WAKE_RESET;
      end else begin
        next_wake_cnt = wake_cnt - 16'h0001;
      end
    end
    // deselect finishes whatever the frame started
    if (cs_rise) begin
      next_rel_pend = 1'b0;
      next_deep_pend = 1'b0;
      next_lset_pend = 1'b0;
      if (rel_any) begin
        if (next_from_deep) begin
          next_state = ST_WAKING;
          next_wake_cnt = full_sync ? WAKE_READ_CYC :
            WAKE_SHORT_CYC;
        end else begin
          next_state = ST_STANDBY;
        end
      end else if (deep_any && only_sync && !busy) begin
        next_state = ST_DEEP;
      end
      if (lset_any && only_sync && write_ok && !busy) begin
        next_wel = 1'b1;
      end
    end
    // engine clears the latch; a set in the same cycle wins
    if (write_latch_clear_in && !(cs_rise && lset_any && only_sync &&
        write_ok && !busy)) begin
      next_wel = 1'b0;
    end
    next_status = STATUS_RESET;
    next_status[LATCH_BIT] = next_wel;
    next_status[BUSY_BIT] = busy;
  end

  // power-up state: standby, latch clear, status zero
  always_ff @(posedge clk_in) begin
    if (hold_rst) begin
      state <= ST_STANDBY;
      wake_cnt <= WAKE_RESET;
      rel_pend <= 1'b0;
      from_deep <= 1'b0;
      deep_pend <= 1'b0;
      lset_pend <= 1'b0;
      write_latch_flag <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_code_out <= 8'h00;
      deep_pd_out <= 1'b0;
      waking_out <= 1'b0;
      write_ready_out <= 1'b0;
      status_out <= STATUS_RESET;
    end else begin
      state <= next_state;
      wake_cnt <= next_wake_cnt;
      rel_pend <= next_rel_pend;
      from_deep <= next_from_deep;
      deep_pend <= next_deep_pend;
      lset_pend <= next_lset_pend;
      write_latch_flag <= next_wel;
      cmd_valid_out <= next_cmd_valid;
      cmd_code_out <= next_cmd_code;
      deep_pd_out <= (next_state == ST_DEEP);
      waking_out <= (next_state == ST_WAKING);
      write_ready_out <= write_ok;
      status_out <= next_status;
    end
  end

  // signature drive request toward the serial side
  assign lnk.sig_go = rel_pend;
endmodule

// file: hdl/power_gate.sv
`timescale 1ns/100ps
module power_gate
  import flash_wake_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYCLES_DEF
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // synchronous reset
  input wire logic supply_on_clear_in, // supply below inhibit level
  input wire logic supply_valid_in, // supply at operating level
  output logic core_rst_out, // holds the logic in reset
  output logic select_ok_out, // instructions may be served
  output logic write_ok_out // write hold-off elapsed
);
  localparam logic [19:0] HOLD_TOP = 20'(HOLDOFF_CYCLES);
  logic por_meta, por_sync, val_meta, val_sync;
  logic [19:0] hold_cnt, next_hold_cnt;
  logic [9:0] sel_cnt, next_sel_cnt;
  logic next_core_rst, next_select_ok, next_write_ok;

  // select timer restarts when the supply leaves operating level, hold-off timer only when it falls below inhibit
  always_comb begin
    next_core_rst = por_sync;
    next_hold_cnt = por_sync ? 20'h00000 :
      (hold_cnt == HOLD_TOP) ? hold_cnt : hold_cnt + 20'h00001;
    next_sel_cnt = (por_sync || !val_sync) ? 10'h000 :
      (sel_cnt == SELECT_CYCLES) ? sel_cnt : sel_cnt + 10'h001;
    next_write_ok = !por_sync && hold_cnt == HOLD_TOP;
    next_select_ok = !por_sync && val_sync &&
      sel_cnt == SELECT_CYCLES;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      por_meta <= 1'b1;
      por_sync <= 1'b1;
      val_meta <= 1'b0;
      val_sync <= 1'b0;
      hold_cnt <= 20'h00000;
      sel_cnt <= 10'h000;
      core_rst_out <= 1'b1;
      select_ok_out <= 1'b0;
      write_ok_out <= 1'b0;
    end else begin
      por_meta <= supply_on_clear_in;
      por_sync <= por_meta;
      val_meta <= supply_valid_in;
      val_sync <= val_meta;
      hold_cnt <= next_hold_cnt;
      sel_cnt <= next_sel_cnt;
      core_rst_out <= next_core_rst;
      select_ok_out <= next_select_ok;
      write_ok_out <= next_write_ok;
    end
  end
endmodule

// file: hdl/sig_shifter.sv
`timescale 1ns/100ps
module sig_shifter
  import flash_wake_pkg::*;
#(
  parameter logic [7:0] SIGNATURE = SIGNATURE_DEF
) (
  input wire logic sclk_in, // serial clock
  input wire logic cs_n_in, // chip select, low selects
  input wire logic mosi_in, // serial data in
  input wire logic rst_in, // clears frame flags
  output logic miso_out, // serial data out
  output logic miso_oe_n_out, // low while driving
  wake_link_if.link_side lnk // to system side
);
  logic [5:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic go_meta, next_go_meta, go_sync, next_go_sync;
  logic [7:0] op_byte, next_op_byte;
  logic op_toggle, next_op_toggle, op_only, next_op_only;
  logic sig_full, next_sig_full;
  logic [2:0] out_idx, next_out_idx;
  logic miso, next_miso, oe_n, next_oe_n;

  // ----------------------------------------------------------------
  // input side, rising edge
  // ----------------------------------------------------------------
  always_comb begin
    next_bit_cnt = (bit_cnt == BIT_FULL) ? bit_cnt : bit_cnt + 6'h01;
    next_shift = {shift[6:0], mosi_in};
    next_go_meta = lnk.sig_go;
    next_go_sync = go_meta;
    next_op_byte = op_byte;
    next_op_toggle = op_toggle;
    next_op_only = (bit_cnt == BIT_OP - 6'h01);
    next_sig_full = (bit_cnt == BIT_FULL - 6'h01) ||
      (sig_full && bit_cnt != 6'h00);
    if (bit_cnt == BIT_OP - 6'h01) begin
      next_op_byte = {shift[6:0], mosi_in};
      next_op_toggle = ~op_toggle;
    end
  end

  // frame counters end with the frame itself
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= 6'h00;
      shift <= 8'h00;
      go_meta <= 1'b0;
      go_sync <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
      go_meta <= next_go_meta;
      go_sync <= next_go_sync;
    end
  end

  // flags outlive the frame for the system side to read
  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      op_byte <= 8'h00;
      op_toggle <= 1'b0;
      op_only <= 1'b0;
      sig_full <= 1'b0;
    end else begin
      op_byte <= next_op_byte;
      op_toggle <= next_op_toggle;
      op_only <= next_op_only;
      sig_full <= next_sig_full;
    end
  end

  // ----------------------------------------------------------------
  // output side, falling edge
  // ----------------------------------------------------------------
  always_comb begin
    next_out_idx = out_idx;
    next_miso = miso;
    next_oe_n = oe_n;
    if (go_sync && bit_cnt >= BIT_SIG) begin
      next_miso = SIGNATURE[3'h7 - out_idx];
      next_out_idx = out_idx + 3'h1;
      next_oe_n = 1'b0;
    end
  end

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      out_idx <= 3'h0;
      miso <= 1'b0;
      oe_n <= 1'b1;
    end else begin
      out_idx <= next_out_idx;
      miso <= next_miso;
      oe_n <= next_oe_n;
    end
  end

  assign miso_out = miso;
  assign miso_oe_n_out = oe_n;
  assign lnk.op_byte = op_byte;
  assign lnk.op_toggle = op_toggle;
  assign lnk.op_only = op_only;
  assign lnk.sig_full = sig_full;
endmodule

// file: hdl/wake_link_if.sv
`timescale 1ns/100ps
// crossing between serial-clock logic and system-clock logic
interface wake_link_if;
  logic [7:0] op_byte; // last instruction byte, stable until next
  logic op_toggle; // flips once per instruction byte
  logic op_only; // frame holds exactly eight bits so far
  logic sig_full; // frame delivered a whole signature
  logic sig_go; // system side: drive the signature
  modport link_side (
    output op_byte, op_toggle, op_only, sig_full,
    input sig_go
  );
  modport sys_side (
    input op_byte, op_toggle, op_only, sig_full,
    output sig_go
  );
endinterface

// file: sim/flash_wake_props.sv
`timescale 1ns/100ps
// watches the top-level pins of the wake and power-up block
module flash_wake_props
  import flash_wake_pkg::*;
#(
  parameter int WAKE_SHORT_NS = WAKE_SHORT_NS_DEF
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // reset
  input wire logic sclk_in, // serial clock
  input wire logic cs_n_in, // select
  input wire logic mosi_in, // data in
  input wire logic miso_out, // data out
  input wire logic miso_oe_n_out, // drive enable
  input wire logic supply_on_clear_in, // supply low
  input wire logic supply_valid_in, // supply good
  input wire logic cycle_active_in, // cycle busy
  input wire logic write_latch_clear_in, // latch clear
  input wire logic cmd_valid_out, // command pulse
  input wire logic [7:0] cmd_code_out, // command code
  input wire logic deep_pd_out, // deep state
  input wire logic waking_out, // wake delay
  input wire logic write_ready_out, // hold-off done
  input wire logic [7:0] status_out // status
);
  localparam int WAKE_MAX = WAKE_SHORT_NS / CLK_PERIOD_NS + 20;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // --------------------------------------------------------------
  // pin relations
  // --------------------------------------------------------------
  oe_needs_cs_a: assert property (!miso_oe_n_out |-> !cs_n_in)
    else $error("data out driven while deselected");
  oe_release_a: assert property (cs_n_in |-> miso_oe_n_out)
    else $error("data out still driven after deselect");
  wake_not_deep_a: assert property (waking_out |-> !deep_pd_out)
    else $error("waking and deep at once");
  wake_bound_a: assert property (
    $rose(waking_out) |-> ##[1:WAKE_MAX] !waking_out)
    else $error("wake delay too long");
  deep_idle_a: assert property (
    $rose(deep_pd_out) |-> !$past(cycle_active_in, 1))
    else $error("deep entered during busy cycle");
  status_zero_a: assert property (status_out[7:2] == 6'h00)
    else $error("unused status bits set");
  latch_holdoff_a: assert property (
    $rose(status_out[LATCH_BIT]) |-> write_ready_out)
    else $error("write latch set during hold-off");
  cmd_awake_a: assert property (cmd_valid_out |->
    !$past(deep_pd_out, 2) && !$past(waking_out, 2))
    else $error("command passed on while asleep");
  supply_off_a: assert property (supply_on_clear_in [*8] |->
    !deep_pd_out && !waking_out && !write_ready_out &&
    !cmd_valid_out && status_out == 8'h00)
    else $error("logic active with supply low");
endmodule
bind flash_wake_signature_powerup flash_wake_props #(
  .WAKE_SHORT_NS(WAKE_SHORT_NS)
) i_flash_wake_props (.*);

// file: sim/flash_wake_signature_powerup_tb.sv
`timescale 1ns/100ps
module flash_wake_signature_powerup_tb;
  import flash_wake_pkg::*;
  localparam int HOLD = 3000;
  localparam int RD = WAKE_READ_NS_DEF / CLK_PERIOD_NS;
  localparam int SH = WAKE_SHORT_NS_DEF / CLK_PERIOD_NS;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic sclk_in, cs_n_in, mosi_in, miso_out, miso_oe_n_out;
  logic supply_on_clear_in = 1'h1;
  logic supply_valid_in = 1'h0;
  logic cycle_active_in = 1'h0;
  logic write_latch_clear_in = 1'h0;
  logic cmd_valid_out, deep_pd_out, waking_out, write_ready_out;
  logic [7:0] cmd_code_out, status_out, op;
  logic [7:0] exp_q[$];
  logic [7:0] wr_ops[5] = '{OP_LATCH_SET_DEF, OP_PAGE_WR_DEF,
    OP_BLOCK_WIPE_DEF, OP_ALL_WIPE_DEF, OP_STATUS_WR_DEF};
  logic [31:0] seed = 32'h3751BC96;
  logic [15:0] g;
  logic d;
  int failures = 0;
  int comparisons = 0;
  int wake_n = 0;

  always #5 clk_in = ~clk_in;

  flash_wake_signature_powerup #(.HOLDOFF_CYCLES(HOLD))
  i_flash_wake_signature_powerup (.*);

  spi_host_model i_spi_host_model (
    .sclk_out(sclk_in),
    .cs_n_out(cs_n_in),
    .mosi_out(mosi_in),
    .miso_in(miso_out),
    .miso_oe_n_in(miso_oe_n_out)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic report_and_stop();
    if (failures == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp1(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic cmpv(input logic [15:0] got, input logic [15:0] exp,
    input string m);
    cmp1(got === exp, 1'h1, m);
  endtask

  task automatic frame(input logic [7:0] o, input int n);
    seed = xs(seed);
    i_spi_host_model.xfer(o, n, seed, g, d);
    repeat (10) @(negedge clk_in);
  endtask

  // single-byte command; a pass-on pulse is noted if expected
  task automatic send(input logic [7:0] o, input logic pulse);
    if (pulse) exp_q.push_back(o);
    frame(o, 8);
  endtask

  // release frame, then hold select high for the whole wake delay
  task automatic wake(input int n);
    wake_n = 0;
    frame(OP_RELEASE_DEF, n);
    for (int i = 0; i < 1000 && waking_out !== 1'h0; i++)
      @(negedge clk_in);
    if (waking_out !== 1'h0) begin
      failures++;
      report_and_stop();
    end
  endtask

  // wake delay length and pass-on pulses
  always @(posedge clk_in) begin
    if (waking_out === 1'h1) wake_n++;
    if (cmd_valid_out === 1'h1) begin
      if (exp_q.size() == 0) cmp1(1'h1, 1'h0, "unexpected command");
      else cmpv({8'h00, cmd_code_out}, {8'h00, exp_q.pop_front()},
        "command code");
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(negedge clk_in);
    rst_in = 1'h0;
    supply_on_clear_in = 1'h0;
    supply_valid_in = 1'h1;
    repeat (6) @(negedge clk_in);
    cmp1(deep_pd_out, 1'h0, "deep at power-up");
    cmpv({8'h00, status_out}, 16'h0000, "status at power-up");
    send(8'h0B, 1'h0);
    repeat (1000) @(negedge clk_in);
    foreach (wr_ops[i]) send(wr_ops[i], 1'h0);
    cmp1(status_out[LATCH_BIT], 1'h0, "latch set in hold-off");
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      op = {1'h0, seed[6:0]};
      send(op, 1'h1);
    end
    for (int i = 0; i < HOLD && write_ready_out !== 1'h1; i++)
      @(negedge clk_in);
    cmp1(write_ready_out, 1'h1, "hold-off never ends");
    if (write_ready_out !== 1'h1) report_and_stop();
    send(OP_LATCH_SET_DEF, 1'h0);
    cmp1(status_out[LATCH_BIT], 1'h1, "latch not set");
    write_latch_clear_in = 1'h1;
    @(negedge clk_in);
    write_latch_clear_in = 1'h0;
    repeat (4) @(negedge clk_in);
    cmp1(status_out[LATCH_BIT], 1'h0, "latch not cleared");
    wake(48);
    cmpv(g, {2{SIGNATURE_DEF}}, "signature repeat");
    cmp1(d, 1'h1, "data out never driven");
    cmp1(wake_n == 0, 1'h1, "delay when awake");
    send(OP_DEEP_DEF, 1'h0);
    cmp1(deep_pd_out, 1'h1, "deep not entered");
    send(8'h0B, 1'h0);
    send(OP_LATCH_SET_DEF, 1'h0);
    cmp1(status_out[LATCH_BIT], 1'h0, "latch set in deep");
    cmp1(deep_pd_out, 1'h1, "deep left early");
    wake(40);
    cmpv(g, {8'h00, SIGNATURE_DEF}, "signature from deep");
    cmp1(deep_pd_out, 1'h0, "still deep");
    cmp1(wake_n >= RD && wake_n <= RD + 6, 1'h1, "long delay");
    send(OP_DEEP_DEF, 1'h0);
    wake(20);
    cmp1(d, 1'h0, "early deselect drove data");
    cmp1(wake_n >= SH && wake_n <= SH + 6, 1'h1, "short delay");
    cycle_active_in = 1'h1;
    repeat (4) @(negedge clk_in);
    cmp1(status_out[BUSY_BIT], 1'h1, "busy bit");
    send(OP_DEEP_DEF, 1'h0);
    cmp1(deep_pd_out, 1'h0, "deep during busy");
    frame(OP_RELEASE_DEF, 48);
    cmp1(d, 1'h0, "release decoded while busy");
    cmp1(status_out[BUSY_BIT], 1'h1, "busy disturbed");
    cycle_active_in = 1'h0;
    send(OP_LATCH_SET_DEF, 1'h0);
    supply_on_clear_in = 1'h1;
    repeat (8) @(negedge clk_in);
    cmpv({8'h00, status_out}, 16'h0000, "status kept");
    cmp1(write_ready_out, 1'h0, "write ready kept");
    send(8'h0B, 1'h0);
    supply_on_clear_in = 1'h0;
    repeat (8) @(negedge clk_in);
    cmp1(deep_pd_out, 1'h0, "deep after power-up");
    cmp1(exp_q.size() == 0, 1'h1, "missing command");
    report_and_stop();
  end
endmodule

// file: sim/spi_host_model.sv
`timescale 1ns/100ps
// host side of the link; its clock runs only inside frames
module spi_host_model (
  output logic sclk_out, // serial clock, idle low
  output logic cs_n_out, // select, idle high
  output logic mosi_out, // data to device
  input wire logic miso_in, // data from device
  input wire logic miso_oe_n_in // low while device drives
);
  initial begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    mosi_out = 1'h0;
  end
  // one frame: opcode, filler, capture from bit 32 on
  task automatic xfer(input logic [7:0] op, input int nbits,
    input logic [31:0] fill, output logic [15:0] got,
    output logic drv);
    got = 16'h0000;
    drv = 1'h0;
    #3.3 cs_n_out = 1'h0;
    #6;
    for (int i = 0; i < nbits; i++) begin
      mosi_out = (i < 8) ? op[7 - i] : fill[i % 32];
      #6 sclk_out = 1'h1;
      if (i >= 32) got = {got[14:0], miso_in};
      if (miso_oe_n_in === 1'h0) drv = 1'h1;
      #6 sclk_out = 1'h0;
    end
    #6 cs_n_out = 1'h1;
    mosi_out = ~mosi_out; // released line, not last value
  endtask
endmodule
